// File: verilog/pmc_defs.svh
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH
`define PMC_INIT_NS     1000
`define PMC_CLK_NS      25
`define PMC_INIT_CYC    ((`PMC_INIT_NS + `PMC_CLK_NS - 1) / `PMC_CLK_NS)
`define PMC_MULT_19M2   8'h19
`define PMC_MULT_24M    8'h14
`define PMC_MULT_48M    8'h0a
`define PMC_MULT_26M    8'h12
`define PMC_SEL_19M2    2'h0
`define PMC_SEL_24M     2'h1
`define PMC_SEL_48M     2'h2
`define PMC_SEL_26M     2'h3
`endif

// File: verilog/pmc_pkg.sv
package pmc_pkg;
    typedef enum logic [2:0] {
        PMC_RESET   = 3'b000,
        PMC_INIT    = 3'b001,
        PMC_NORMAL  = 3'b010,
        PMC_DRAIN   = 3'b011,
        PMC_SUSPEND = 3'b100,
        PMC_STANDBY = 3'b101
    } pmc_mode_t;
endpackage

// File: verilog/pmc_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser; output changes once stages two and three agree
module pmc_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic clock_i,
    input  wire logic reset_n_i,
    input  wire logic async_i,
    output logic      sync_o
);
    logic [2:0] stage_q;
    logic [2:0] stage_d;
    logic       out_q;
    logic       out_d;

    // shift chain and agreement filter
    always_comb begin
        stage_d = {stage_q[1:0], async_i};
        out_d   = (stage_q[1] == stage_q[2]) ? stage_q[2] : out_q;
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            stage_q <= {3{RESET_VAL}};
            out_q   <= RESET_VAL;
        end else begin
            stage_q <= stage_d;
            out_q   <= out_d;
        end
    end

    assign sync_o = out_q;
endmodule

// File: verilog/pmc_freq_decode.sv
`timescale 1ns/1ps
`include "pmc_defs.svh"
// reference frequency select to pll multiplier
module pmc_freq_decode (
    input  wire logic [1:0] ref_freq_select_i,
    output logic      [7:0] pll_mult_o
);
    // decode table
    always_comb begin
        case (ref_freq_select_i)
            `PMC_SEL_19M2: pll_mult_o = `PMC_MULT_19M2;
            `PMC_SEL_24M:  pll_mult_o = `PMC_MULT_24M;
            `PMC_SEL_48M:  pll_mult_o = `PMC_MULT_48M;
            default:       pll_mult_o = `PMC_MULT_26M;
        endcase
    end
endmodule

// File: verilog/pmc_power_mode_controller.sv
`timescale 1ns/1ps
`include "pmc_defs.svh"
module pmc_power_mode_controller #(
    parameter int INIT_CYCLES = `PMC_INIT_CYC
) (
    input  wire logic             clock_i,
    input  wire logic             reset_n_i,
    input  wire logic             wake_pin_i,
    input  wire logic             chip_sel_n_i,
    input  wire logic             dplus_i,
    input  wire logic             card_detect_i,
    input  wire logic             card_detect_level_i,
    input  wire logic             wake_en_dplus_i,
    input  wire logic             wake_en_card_i,
    input  wire logic             wake_en_cs_i,
    input  wire logic             suspend_cmd_i,
    input  wire logic             standby_cmd_i,
    input  wire logic             reg_write_i,
    input  wire logic             txn_busy_i,
    input  wire logic             usb_switch_bit_i,
    input  wire logic             crystal_mode_i,
    input  wire logic       [1:0] ref_freq_select_i,
    output pmc_pkg::pmc_mode_t    mode_o,
    output logic                  init_done_out_o,
    output logic                  init_complete_bit_o,
    output logic                  usb_switch_enable_o,
    output logic                  osc_feedback_out_o,
    output logic                  clocks_run_o,
    output logic                  pll_enable_o,
    output logic            [7:0] pll_mult_o,
    output logic                  io_hold_o,
    output logic                  io_tristate_o,
    output logic                  pc_reset_o,
    output logic                  data_path_clear_o
);
    import pmc_pkg::*;

    // all checks run on the core clock and stand down in hard reset
    default clocking cb_core @(posedge clock_i);
    endclocking
    default disable iff (!reset_n_i);

    logic       wake_s;
    logic       cs_n_s;
    logic       dplus_s;
    logic       card_s;
    logic [7:0] mult_w;
    logic [1:0] sel_s;

    // synchronise the asynchronous sense inputs
    // wake starts low so that a pin held low at release never starts init
    pmc_sync #(.RESET_VAL(1'b0)) u_sync_wake (
        .clock_i   (clock_i),
        .reset_n_i (reset_n_i),
        .async_i   (wake_pin_i),
        .sync_o    (wake_s)
    );
    pmc_sync #(.RESET_VAL(1'b1)) u_sync_cs (
        .clock_i   (clock_i),
        .reset_n_i (reset_n_i),
        .async_i   (chip_sel_n_i),
        .sync_o    (cs_n_s)
    );
    pmc_sync #(.RESET_VAL(1'b1)) u_sync_dp (
        .clock_i   (clock_i),
        .reset_n_i (reset_n_i),
        .async_i   (dplus_i),
        .sync_o    (dplus_s)
    );
    pmc_sync #(.RESET_VAL(1'b1)) u_sync_card (
        .clock_i   (clock_i),
        .reset_n_i (reset_n_i),
        .async_i   (card_detect_i),
        .sync_o    (card_s)
    );

    // the frequency select straps are pins too; one synchroniser a bit
    for (genvar b = 0; b < 2; b++) begin : g_sel_sync
        pmc_sync #(.RESET_VAL(1'b0)) u_sync_sel (
            .clock_i   (clock_i),
            .reset_n_i (reset_n_i),
            .async_i   (ref_freq_select_i[b]),
            .sync_o    (sel_s[b])
        );
    end

    pmc_freq_decode u_freq (
        .ref_freq_select_i (sel_s),
        .pll_mult_o        (mult_w)
    );

    pmc_mode_t   mode_q;
    pmc_mode_t   mode_d;
    logic [15:0] init_cnt_q;
    logic [15:0] init_cnt_d;
    logic        pin_entry_q;
    logic        pin_entry_d;
    logic        done_q;
    logic        done_d;
    logic        usb_q;
    logic        usb_d;
    logic        osc_q;
    logic        osc_d;
    logic        run_q;
    logic        run_d;
    logic        pll_q;
    logic        pll_d;
    logic [7:0]  mult_q;
    logic        hold_q;
    logic        hold_d;
    logic        tri_q;
    logic        tri_d;
    logic        pcr_q;
    logic        pcr_d;
    logic        clr_q;
    logic        clr_d;
    logic        susp_wake;
    logic        stby_wake;

    // wake sources; only these pins are looked at in the low-power modes
    always_comb begin
        susp_wake = (wake_en_dplus_i && !dplus_s)
                 || (wake_en_card_i && (card_s == card_detect_level_i))
                 || (wake_en_cs_i && !cs_n_s);
        stby_wake = (pin_entry_q && wake_s) || !cs_n_s
                 || reg_write_i;
    end

    // mode sequencing
    always_comb begin
        mode_d      = mode_q;
        init_cnt_d  = init_cnt_q;
        pin_entry_d = pin_entry_q;
        pcr_d       = 1'b0;
        clr_d       = 1'b0;
        case (mode_q)
            PMC_RESET: begin
                // wake pin watched here; init waits for it high
                if (wake_s) begin
                    mode_d     = PMC_INIT;
                    init_cnt_d = 16'h0000;
                end
            end
            PMC_INIT: begin
                if (init_cnt_q == 16'(INIT_CYCLES - 1)) begin
                    mode_d = PMC_NORMAL;
                end else begin
                    init_cnt_d = init_cnt_q + 16'h0001;
                end
            end
            PMC_NORMAL: begin
                if (!wake_s) begin
                    mode_d      = PMC_STANDBY;
                    pin_entry_d = 1'b1;
                end else if (standby_cmd_i) begin
                    mode_d      = PMC_STANDBY;
                    pin_entry_d = 1'b0;
                end else if (suspend_cmd_i) begin
                    mode_d = PMC_DRAIN;
                end
            end
            PMC_DRAIN: begin
                if (!txn_busy_i) begin
                    mode_d = PMC_SUSPEND;
                end
            end
            PMC_SUSPEND: begin
                // state held, pc untouched on resume
                if (susp_wake) begin
                    mode_d = PMC_NORMAL;
                end
            end
            PMC_STANDBY: begin
                if (stby_wake) begin
                    mode_d = PMC_NORMAL;
                    pcr_d  = 1'b1;
                    clr_d  = 1'b1;
                end
            end
            default: mode_d = PMC_RESET;
        endcase
    end

    // output levels per mode
    always_comb begin
        done_d = (mode_d != PMC_RESET) && (mode_d != PMC_INIT);
        run_d  = (mode_d != PMC_SUSPEND) && (mode_d != PMC_STANDBY);
        hold_d = (mode_d == PMC_SUSPEND);
        tri_d  = (mode_d == PMC_STANDBY);
        pll_d  = (mode_d != PMC_STANDBY) && (mode_d != PMC_SUSPEND);
        usb_d  = (mode_d == PMC_NORMAL || mode_d == PMC_DRAIN
                  || mode_d == PMC_SUSPEND) && usb_switch_bit_i;
        if (mode_d == PMC_STANDBY || !crystal_mode_i) begin
            osc_d = 1'b1;
        end else if (mode_d == PMC_SUSPEND) begin
            osc_d = osc_q;
        end else begin
            osc_d = !osc_q;
        end
    end

    // asynchronous hard reset returns everything to reset
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_q      <= PMC_RESET;
            init_cnt_q  <= 16'h0000;
            pin_entry_q <= 1'b0;
            done_q      <= 1'b0;
            usb_q       <= 1'b0;
            osc_q       <= 1'b1;
            run_q       <= 1'b1;
            pll_q       <= 1'b1;
            mult_q      <= 8'h00;
            hold_q      <= 1'b0;
            tri_q       <= 1'b0;
            pcr_q       <= 1'b1;
            clr_q       <= 1'b1;
        end else begin
            mode_q      <= mode_d;
            init_cnt_q  <= init_cnt_d;
            pin_entry_q <= pin_entry_d;
            done_q      <= done_d;
            usb_q       <= usb_d;
            osc_q       <= osc_d;
            run_q       <= run_d;
            pll_q       <= pll_d;
            mult_q      <= mult_w;
            hold_q      <= hold_d;
            tri_q       <= tri_d;
            pcr_q       <= pcr_d;
            clr_q       <= clr_d;
        end
    end

    assign mode_o              = mode_q;
    assign init_done_out_o     = done_q;
    assign init_complete_bit_o = done_q;
    assign usb_switch_enable_o = usb_q;
    assign osc_feedback_out_o  = osc_q;
    assign clocks_run_o        = run_q;
    assign pll_enable_o        = pll_q;
    assign pll_mult_o          = mult_q;
    assign io_hold_o           = hold_q;
    assign io_tristate_o       = tri_q;
    assign pc_reset_o          = pcr_q;
    assign data_path_clear_o   = clr_q;

    // core power-down loss is the host's reload duty

    // checks on mode sequencing
    a_drain_no_busy: assert property (
        mode_q == PMC_DRAIN && txn_busy_i |=> mode_q == PMC_DRAIN)
        else $error("suspend entered with busy transaction");
    a_suspend_entry: assert property (
        mode_q != PMC_DRAIN && mode_q != PMC_SUSPEND |=> mode_q != PMC_SUSPEND)
        else $error("suspend entered without drain");
    a_standby_pcr: assert property (
        mode_q == PMC_STANDBY && mode_d == PMC_NORMAL |=> pc_reset_o)
        else $error("no pc reset after standby");
    a_suspend_pc: assert property (
        mode_q == PMC_SUSPEND |=> !pc_reset_o)
        else $error("pc reset after suspend");
    a_pin_standby: assert property (
        mode_q == PMC_NORMAL && !wake_s |=> mode_q == PMC_STANDBY)
        else $error("wake pin low did not enter standby");
    a_standby_reg: assert property (
        mode_q == PMC_STANDBY && !pin_entry_q && cs_n_s && !reg_write_i
        |=> mode_q == PMC_STANDBY)
        else $error("register standby left without cause");
    a_init_wake: assert property (
        mode_q == PMC_RESET && !wake_s |=> mode_q == PMC_RESET)
        else $error("init started with wake pin low");

    // checks on output levels
    a_usb_standby: assert property (
        mode_q == PMC_STANDBY |-> !usb_switch_enable_o)
        else $error("usb switch high in standby");
    a_usb_reset: assert property (
        mode_q == PMC_RESET |-> !usb_switch_enable_o)
        else $error("usb switch high in reset");
    a_usb_follow: assert property (
        mode_d == PMC_NORMAL
        |=> usb_switch_enable_o == $past(usb_switch_bit_i))
        else $error("usb switch does not follow its bit");
    a_osc_standby: assert property (
        mode_q == PMC_STANDBY |-> osc_feedback_out_o)
        else $error("osc feedback low in standby");
    a_osc_toggle: assert property (
        mode_q == PMC_NORMAL && mode_d == PMC_NORMAL && crystal_mode_i
        |=> osc_feedback_out_o != $past(osc_feedback_out_o))
        else $error("osc feedback not toggling with crystal");
    a_done_init: assert property (
        init_done_out_o |-> mode_q != PMC_RESET && mode_q != PMC_INIT)
        else $error("reset complete too early");
    a_standby_out: assert property (
        mode_q == PMC_STANDBY |-> io_tristate_o && !pll_enable_o)
        else $error("standby outputs wrong");
    a_suspend_out: assert property (
        mode_q == PMC_SUSPEND |-> io_hold_o && !clocks_run_o)
        else $error("suspend outputs wrong");
    a_mult_48m: assert property (
        sel_s == `PMC_SEL_48M |=> pll_mult_o == `PMC_MULT_48M)
        else $error("pll multiplier wrong for 48 mhz");

    // main scenarios
    c_suspend: cover property (
        mode_q == PMC_SUSPEND ##1 mode_q == PMC_NORMAL);
    c_standby: cover property (
        mode_q == PMC_STANDBY ##1 mode_q == PMC_NORMAL);
    c_init: cover property (
        mode_q == PMC_INIT ##1 mode_q == PMC_NORMAL);
    c_drain: cover property (
        mode_q == PMC_DRAIN ##1 mode_q == PMC_SUSPEND);
endmodule

// File: testbench/pmc_host_model.sv
`timescale 1ns/1ps
// host side of the block: wake pin, chip select and register write
module pmc_host_model (
    input  wire logic clock_i,
    input  wire logic wake_req_i,
    input  wire logic cs_req_i,
    input  wire logic wr_req_i,
    output logic      wake_pin_o,
    output logic      chip_sel_n_o,
    output logic      reg_write_o
);
    logic wr_q;
    // idle levels until the first edge
    initial begin
        wake_pin_o = 1'b1;
        chip_sel_n_o = 1'b1;
        reg_write_o = 1'b0;
        wr_q = 1'b0;
    end
    // pins change just after the edge; a write lasts one cycle
    always @(posedge clock_i) begin
        wake_pin_o <= wake_req_i;
        chip_sel_n_o <= !cs_req_i;
        reg_write_o <= wr_req_i && !wr_q;
        wr_q <= wr_req_i;
    end
endmodule

// File: testbench/tb.sv
`timescale 1ns/1ps
module tb;
    import pmc_pkg::*;
    localparam int INIT_N = 4;
    logic clock, reset_n = 1'b0, wake_req = 1'b1, cs_req = 1'b0;
    logic wr_req = 1'b0, dplus = 1'b1, card = 1'b1, card_lvl = 1'b0;
    logic en_dp = 1'b0, en_cd = 1'b0, en_cs = 1'b0, susp_cmd = 1'b0;
    logic stby_cmd = 1'b0, busy = 1'b0, usb_bit = 1'b1, xtal = 1'b0;
    logic [1:0] fsel = 2'h0;
    logic wake_pin, chip_sel_n, reg_write, done, cbit, usb_en, osc;
    logic run, pll, hold, tri_s, pc_rst, clr, osc_a;
    logic [7:0] mult;
    pmc_mode_t mode, mode_p;
    int failures = 0, comparisons = 0, pc_cnt = 0, pc_base;
    int clr_cnt = 0, clr_base;
    int seed = 32'hd8ebe085;

    pmc_host_model host (.clock_i(clock), .wake_req_i(wake_req),
        .cs_req_i(cs_req), .wr_req_i(wr_req), .wake_pin_o(wake_pin),
        .chip_sel_n_o(chip_sel_n), .reg_write_o(reg_write));

    pmc_power_mode_controller #(.INIT_CYCLES(INIT_N)) uut (
        .clock_i(clock), .reset_n_i(reset_n), .wake_pin_i(wake_pin),
        .chip_sel_n_i(chip_sel_n), .dplus_i(dplus), .card_detect_i(card),
        .card_detect_level_i(card_lvl), .wake_en_dplus_i(en_dp),
        .wake_en_card_i(en_cd), .wake_en_cs_i(en_cs),
        .suspend_cmd_i(susp_cmd), .standby_cmd_i(stby_cmd),
        .reg_write_i(reg_write), .txn_busy_i(busy),
        .usb_switch_bit_i(usb_bit), .crystal_mode_i(xtal),
        .ref_freq_select_i(fsel), .mode_o(mode), .init_done_out_o(done),
        .init_complete_bit_o(cbit), .usb_switch_enable_o(usb_en),
        .osc_feedback_out_o(osc), .clocks_run_o(run), .pll_enable_o(pll),
        .pll_mult_o(mult), .io_hold_o(hold), .io_tristate_o(tri_s),
        .pc_reset_o(pc_rst), .data_path_clear_o(clr));

    // 40 mhz clock
    initial begin
        clock = 1'b0;
        forever #12.5 clock = !clock;
    end

    // counts pc restarts and data path clears on leaving a low-power mode
    always @(posedge clock) begin
        if (mode_p === PMC_STANDBY || mode_p === PMC_SUSPEND) begin
            if (pc_rst === 1'b1)
                pc_cnt++;
            if (clr === 1'b1)
                clr_cnt++;
        end
        mode_p = mode;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    // one edge on, the counters have seen the wake-up cycle
    task automatic wake_counts(input int pcs, input int clrs);
        @(negedge clock);
        check(8'(pc_cnt - pc_base), 8'(pcs));
        check(8'(clr_cnt - clr_base), 8'(clrs));
    endtask

    // bounded wait for a mode, then compare
    task automatic wait_mode(input pmc_mode_t m);
        for (int i = 0; i < 20 && mode !== m; i++) @(negedge clock);
        check(8'(mode), 8'(m));
    endtask

    function automatic logic [7:0] mult_of(input logic [1:0] s);
        case (s)
            2'h0: return 8'h19;
            2'h1: return 8'h14;
            2'h2: return 8'h0a;
            default: return 8'h12;
        endcase
    endfunction

    task automatic tally_and_finish;
        $display("Comparisons %0d, failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        cyc(4000);
        failures++;
        tally_and_finish;
    end

    // main sequence
    initial begin
        cyc(3);
        @(negedge clock);
        check(8'(mode), 8'(PMC_RESET));
        check(8'({done, usb_en, osc}), 8'h1);
        cyc(13);
        reset_n <= 1'b1;
        wait_mode(PMC_INIT);
        cyc(INIT_N - 1);
        @(negedge clock);
        check(8'({done, cbit}), 8'h0);
        cyc(1);
        @(negedge clock);
        check(8'(mode), 8'(PMC_NORMAL));
        check(8'({done, cbit}), 8'h3);
        for (int i = 0; i < 8; i++) begin
            @(posedge clock);
            fsel <= 2'(i);
            usb_bit <= 1'($random(seed));
            cyc(5);
            @(negedge clock);
            check(mult, mult_of(fsel));
            check(8'(usb_en), 8'(usb_bit));
        end
        @(posedge clock);
        xtal <= 1'b1;
        cyc(2);
        @(negedge clock);
        osc_a = osc;
        @(negedge clock);
        check(8'(osc ^ osc_a), 8'h1);
        // one suspend per wake source, first with all sources disabled
        for (int s = 0; s < 3; s++) begin
            {pc_base, clr_base} = {pc_cnt, clr_cnt};
            @(posedge clock);
            busy <= 1'b1;
            susp_cmd <= 1'b1;
            @(posedge clock);
            susp_cmd <= 1'b0;
            cyc(6);
            @(negedge clock);
            check(8'(mode), 8'(PMC_DRAIN));
            @(posedge clock);
            busy <= 1'b0;
            wait_mode(PMC_SUSPEND);
            check(8'({run, pll, hold}), 8'h1);
            @(posedge clock);
            dplus <= (s != 0);
            card <= (s == 1) ? card_lvl : !card_lvl;
            cs_req <= (s == 2);
            cyc(8);
            @(negedge clock);
            check(8'(mode), 8'(PMC_SUSPEND));
            @(posedge clock);
            en_dp <= (s == 0);
            en_cd <= (s == 1);
            en_cs <= (s == 2);
            wait_mode(PMC_NORMAL);
            wake_counts(0, 0);
            @(posedge clock);
            {dplus, card, cs_req} <= {1'b1, !card_lvl, 1'b0};
            {en_dp, en_cd, en_cs} <= 3'h0;
        end
        @(posedge clock);
        wake_req <= 1'b0;
        usb_bit <= 1'b1;
        wait_mode(PMC_STANDBY);
        check(8'({tri_s, pll, usb_en, osc}), 8'h9);
        {pc_base, clr_base} = {pc_cnt, clr_cnt};
        @(posedge clock);
        wake_req <= 1'b1;
        wait_mode(PMC_NORMAL);
        wake_counts(1, 1);
        // register-entered standby ignores the high wake pin
        for (int k = 0; k < 2; k++) begin
            {pc_base, clr_base} = {pc_cnt, clr_cnt};
            @(posedge clock);
            stby_cmd <= 1'b1;
            @(posedge clock);
            stby_cmd <= 1'b0;
            cyc(8);
            @(negedge clock);
            check(8'(mode), 8'(PMC_STANDBY));
            @(posedge clock);
            wr_req <= (k == 0);
            cs_req <= (k == 1);
            wait_mode(PMC_NORMAL);
            wake_counts(1, 1);
            @(posedge clock);
            wr_req <= 1'b0;
            cs_req <= 1'b0;
        end
        @(posedge clock);
        wake_req <= 1'b0;
        wait_mode(PMC_STANDBY);
        @(posedge clock);
        reset_n <= 1'b0;
        wake_req <= 1'b1;
        cyc(4);
        @(negedge clock);
        check(8'({mode, done}), {4'h0, PMC_RESET, 1'b0});
        check(8'({pc_rst, clr, hold, tri_s}), 8'h0c);
        @(posedge clock);
        reset_n <= 1'b1;
        wait_mode(PMC_NORMAL);
        tally_and_finish;
    end
endmodule
